// ### vss_consts.svh
// constants for the variable length synchronous serial block
//Contract
//- characters of 1 to 8 bits move on the shared serial clock
//- internal clock selected gives count clock over 2 times (compare plus 2)
//- external clock selected takes the serial clock from the clock pin
//- internal clock comes from an inverting waveform channel paced by channel 0 compare
//- transmission starts only when transmit enabled and buffer holds a character
//- reception starts only when receive and transmit enabled and character pending
//- irq source 0 requests transmit irq when buffer moves into shifter
//- irq source 1 requests transmit irq when shifter finishes its character
//- receive irq requested when finished character moves into receive buffer
//- overrun flagged when next last bit arrives before receive buffer read
//- bit order selects least or most significant bit first
//- optional inversion of serial output and sampled serial input
//- transmit word holds data and length; receive word holds data and error
//- length field bits 10 to 8, zero means 8 bits, else value bits
//- status shows shifter empty, transmit buffer empty, receive buffer full
`ifndef VSS_CONSTS_SVH
`define VSS_CONSTS_SVH
`define VSS_LEN_LSB 8
`define VSS_LEN_MSB 10
`define VSS_ERR_BIT 15
`define VSS_FIFO_DEPTH 16
`define VSS_FIFO_AW 4
`define VSS_CNT_ONE 16'h0001
`define VSS_BITS_EIGHT 4'h8
`endif

// ### vss_pkg.sv
// types for the variable length synchronous serial block
package vss_pkg;
	typedef enum logic [1:0] {VSS_IDLE, VSS_SHIFT, VSS_DONE} vss_state_t;
endpackage : vss_pkg

// ### vss_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module vss_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;
	assign o_in_ready = (count < (AW+1)'(DEPTH));
	assign o_out_valid = (count != '0);
	assign o_out_data = mem[rd_ptr];
	assign push = i_ce && i_in_valid && o_in_ready;
	assign pop = i_ce && o_out_valid && i_out_ready;
	always_ff @(posedge i_sys_clk) begin
		if (push) begin
			mem[wr_ptr] <= i_in_data;
		end
	end
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : vss_fifo
`default_nettype wire

// ### vss_serial.sv
// variable length synchronous serial transmitter/receiver
`timescale 1ns/10ps
`default_nettype none
`include "vss_consts.svh"
module vss_serial (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_clock_source_sel,
	input wire logic i_bit_order_sel,
	input wire logic i_tx_irq_source_sel,
	input wire logic i_tx_enable_flag,
	input wire logic i_rx_enable_flag,
	input wire logic i_tx_polarity_inv,
	input wire logic i_rx_polarity_inv,
	input wire logic [15:0] i_chan0_compare,
	input wire logic i_tx_buffer_valid,
	output logic o_tx_buffer_ready,
	input wire logic [15:0] i_tx_buffer,
	output logic o_rx_buffer_valid,
	input wire logic i_rx_buffer_read,
	output logic [15:0] o_rx_buffer,
	output logic o_tx_buffer_empty,
	output logic o_tx_shift_empty,
	output logic o_rx_buffer_full,
	output logic o_tx_irq_request,
	output logic o_rx_irq_request,
	input wire logic i_serial_clock_pin,
	input wire logic i_serial_in_pin,
	output logic o_serial_clock_pin,
	output logic o_serial_clock_oe,
	output logic o_serial_out_pin
);
	import vss_pkg::*;

	// ****************************************
	// transmit fifo and pin synchronisers
	// ****************************************
	logic fifo_valid;
	logic fifo_pop;
	logic fifo_in_ready;
	logic [15:0] fifo_data;
	vss_fifo #(.WIDTH(16), .DEPTH(`VSS_FIFO_DEPTH), .AW(`VSS_FIFO_AW)) u_fifo (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_in_valid(i_tx_buffer_valid && o_tx_buffer_ready),
		.o_in_ready(fifo_in_ready),
		.i_in_data(i_tx_buffer),
		.o_out_valid(fifo_valid),
		.i_out_ready(fifo_pop),
		.o_out_data(fifo_data)
	);

	logic [1:0] sck_sync;
	logic [1:0] rxd_sync;
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			sck_sync <= '0;
			rxd_sync <= '0;
		end else if (i_ce) begin
			sck_sync <= {sck_sync[0], i_serial_clock_pin};
			rxd_sync <= {rxd_sync[0], i_serial_in_pin};
		end
	end

	// ****************************************
	// internal clock generator
	// ****************************************
	// half period is compare+2 count clocks; runs only while a character shifts
	logic [15:0] div_cnt;
	logic int_sck;
	logic active;
	logic int_tick;
	assign int_tick = active && !i_clock_source_sel && (div_cnt == 16'h0000);
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			div_cnt <= '0;
			int_sck <= 1'b1;
		end else if (i_ce) begin
			if (!active || i_clock_source_sel) begin
				div_cnt <= i_chan0_compare + `VSS_CNT_ONE;
				int_sck <= 1'b1;
			end else if (int_tick) begin
				div_cnt <= i_chan0_compare + `VSS_CNT_ONE;
				int_sck <= ~int_sck;
			end else begin
				div_cnt <= div_cnt - `VSS_CNT_ONE;
			end
		end
	end

	// ****************************************
	// clock edge selection
	// ****************************************
	logic ext_prev;
	logic int_prev;
	logic fall_edge;
	logic rise_edge;
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			ext_prev <= 1'b1;
			int_prev <= 1'b1;
		end else if (i_ce) begin
			ext_prev <= sck_sync[1];
			int_prev <= int_sck;
		end
	end
	always_comb begin
		if (i_clock_source_sel) begin
			fall_edge = ext_prev && !sck_sync[1];
			rise_edge = !ext_prev && sck_sync[1];
		end else begin
			fall_edge = int_prev && !int_sck;
			rise_edge = !int_prev && int_sck;
		end
	end

	// ****************************************
	// shifter
	// ****************************************
	vss_state_t state;
	logic [7:0] tx_shift;
	logic [7:0] rx_shift;
	logic [3:0] bit_len;
	logic [3:0] bit_cnt;
	logic rx_on;
	logic start;
	logic [3:0] next_len;
	logic rx_done;
	assign next_len = (fifo_data[`VSS_LEN_MSB:`VSS_LEN_LSB] == 3'h0) ? `VSS_BITS_EIGHT
		: {1'b0, fifo_data[`VSS_LEN_MSB:`VSS_LEN_LSB]};
	assign start = (state == VSS_IDLE) && i_tx_enable_flag && fifo_valid;
	assign fifo_pop = start;
	assign active = (state == VSS_SHIFT);
	assign rx_done = active && rise_edge && (bit_cnt == bit_len - 4'h1);

	function automatic logic [7:0] align(input logic [7:0] d, input logic [3:0] n, input logic msb);
		logic [7:0] r;
		r = d;
		if (msb) begin
			r = d << (4'h8 - n); // msb first: top of the character leaves first
		end
		return r;
	endfunction : align
	logic [7:0] start_word;
	assign start_word = align(fifo_data[7:0], next_len, i_bit_order_sel);

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= VSS_IDLE;
			tx_shift <= '0;
			rx_shift <= '0;
			bit_len <= '0;
			bit_cnt <= '0;
			rx_on <= 1'b0;
			o_serial_out_pin <= 1'b1;
		end else if (i_ce) begin
			unique case (state)
				VSS_IDLE: begin
					if (start) begin
						tx_shift <= start_word;
						bit_len <= next_len;
						bit_cnt <= '0;
						rx_on <= i_rx_enable_flag;
						o_serial_out_pin <= (i_bit_order_sel ? start_word[7] : start_word[0])
							^ i_tx_polarity_inv;
						state <= VSS_SHIFT;
					end
				end
				VSS_SHIFT: begin
					if (fall_edge && bit_cnt != '0) begin
						o_serial_out_pin <= (i_bit_order_sel ? tx_shift[7] : tx_shift[0])
							^ i_tx_polarity_inv;
					end
					if (rise_edge) begin
						rx_shift <= i_bit_order_sel ? {rx_shift[6:0], rxd_sync[1] ^ i_rx_polarity_inv}
							: {rxd_sync[1] ^ i_rx_polarity_inv, rx_shift[7:1]};
						tx_shift <= i_bit_order_sel ? {tx_shift[6:0], 1'b0} : {1'b0, tx_shift[7:1]};
						bit_cnt <= bit_cnt + 4'h1;
						if (bit_cnt == bit_len - 4'h1) begin
							state <= VSS_DONE;
						end
					end
				end
				VSS_DONE: begin
					state <= VSS_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// receive buffer, flags, requests
	// ****************************************
	// lsb-first with short length: data sits in the top bits, justify down
	logic [7:0] rx_capture;
	always_comb begin
		rx_capture = i_bit_order_sel ? {rx_shift[6:0], rxd_sync[1] ^ i_rx_polarity_inv}
			: ({rxd_sync[1] ^ i_rx_polarity_inv, rx_shift[7:1]} >> (4'h8 - bit_len));
		if (i_bit_order_sel && bit_len != `VSS_BITS_EIGHT) begin
			rx_capture = rx_capture & ~(8'hff << bit_len);
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rx_buffer <= '0;
			o_rx_buffer_full <= 1'b0;
			o_rx_buffer_valid <= 1'b0;
		end else if (i_ce) begin
			if (rx_done && rx_on) begin // set wins over read
				o_rx_buffer <= {o_rx_buffer_full && !i_rx_buffer_read, 7'h00, rx_capture};
				o_rx_buffer_full <= 1'b1;
				o_rx_buffer_valid <= 1'b1;
			end else if (i_rx_buffer_read) begin
				o_rx_buffer_full <= 1'b0;
				o_rx_buffer_valid <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_tx_irq_request <= 1'b0;
			o_rx_irq_request <= 1'b0;
			o_tx_buffer_empty <= 1'b1;
			o_tx_shift_empty <= 1'b1;
			o_tx_buffer_ready <= 1'b0;
			o_serial_clock_pin <= 1'b1;
			o_serial_clock_oe <= 1'b0;
		end else if (i_ce) begin
			o_tx_irq_request <= i_tx_irq_source_sel ? (state == VSS_DONE) : start;
			o_rx_irq_request <= rx_done && rx_on;
			o_tx_buffer_empty <= !fifo_valid;
			o_tx_shift_empty <= !(active || start);
			// ready is registered: drop it for a cycle after each push so it never overstates room
			o_tx_buffer_ready <= fifo_in_ready && !(i_tx_buffer_valid && o_tx_buffer_ready);
			o_serial_clock_pin <= int_sck;
			o_serial_clock_oe <= !i_clock_source_sel;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	sequence seq_load;
		i_ce && start;
	endsequence
	sequence seq_sck_toggle;
		i_ce && int_tick;
	endsequence
	AST_START_NEEDS_ENABLE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(state == VSS_SHIFT && $past(state) == VSS_IDLE) |-> $past(i_tx_enable_flag && fifo_valid))
		else $error("shift began without enable and pending word");
	AST_LOAD_LENGTH: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		seq_load |=> (active && bit_cnt == 4'h0 && bit_len == $past(next_len)))
		else $error("character length not loaded at start");
	AST_TX_IRQ_START: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(seq_load ##0 !i_tx_irq_source_sel) |=> o_tx_irq_request)
		else $error("no transmit request at start");
	AST_TX_IRQ_END: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(i_ce && i_tx_irq_source_sel && state == VSS_DONE) |=> o_tx_irq_request)
		else $error("no transmit request at end");
	AST_RX_IRQ_FULL: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_rx_irq_request |-> o_rx_buffer_full)
		else $error("receive request without full buffer");
	AST_OVERRUN_FLAG: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(i_ce && rx_done && rx_on && o_rx_buffer_full && !i_rx_buffer_read)
		|=> o_rx_buffer[`VSS_ERR_BIT])
		else $error("overrun not flagged");
	AST_SCK_RELOAD: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		seq_sck_toggle |=> (div_cnt == $past(i_chan0_compare) + `VSS_CNT_ONE
		&& int_sck != $past(int_sck)))
		else $error("serial clock half period wrong");
endmodule : vss_serial
`default_nettype wire

// ### vss_peer.sv
// peer synchronous serial device model for the serial block bench
`timescale 1ns/10ps
`default_nettype none
module vss_peer (
	input wire logic i_sys_clk,
	input wire logic i_clr,
	input wire logic i_ext,
	input wire logic i_msb,
	input wire logic [3:0] i_nbits,
	input wire logic [7:0] i_reply,
	input wire logic i_sclk,
	input wire logic i_sout,
	output logic o_sclk,
	output logic o_sin,
	output logic [7:0] o_cap,
	output logic [3:0] o_cnt
);
	logic [7:0] sh = 8'h00;
	logic [3:0] lim = 4'h0;
	logic [3:0] div = 4'h0;
	initial o_sclk = 1'b1;
	initial o_sin = 1'b1;
	initial o_cnt = 4'h0;
	initial o_cap = 8'h00;
	// ****
	// clock only inside frames, half period 12 keeps under a twentieth
	// ****
	always @(posedge i_sys_clk) begin
		if (i_clr) begin
			lim <= i_nbits;
			div <= 4'h0;
			o_sclk <= 1'b1;
		end else if (i_ext && (o_cnt < lim || !o_sclk)) begin
			div <= (div == 4'hb) ? 4'h0 : div + 4'h1;
			if (div == 4'hb) o_sclk <= ~o_sclk;
		end
	end
	always @(posedge i_sclk or posedge i_clr) begin
		if (i_clr) o_cnt <= 4'h0;
		else begin
			o_cap <= {o_cap[6:0], i_sout};
			o_cnt <= o_cnt + 4'h1;
		end
	end
	// rotating keeps the reply word whole; no clock edge follows the frame, so the line holds its last bit
	always @(negedge i_sclk or posedge i_clr) begin
		if (i_clr) sh <= i_reply;
		else begin
			o_sin <= i_msb ? sh[7] : sh[0];
			sh <= i_msb ? {sh[6:0], sh[7]} : {sh[0], sh[7:1]};
		end
	end
endmodule : vss_peer
`default_nettype wire

// ### vss_serial_tb.sv
// self-checking bench for the variable length synchronous serial block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
	$display("BAD %s exp %h got %h", n, e, a); end end
module vss_serial_tb;
	typedef struct {logic [7:0] cap, cm; logic [15:0] rx, rm;} vss_note_t;
	vss_note_t notes[$];
	vss_note_t nt;
	logic clk = 0, rst = 1, csel = 0, ord = 0, isrc = 0, ten = 0, ren = 0, tinv = 0, rinv = 0;
	logic tval = 0, rrd = 0, clr = 0, noread = 0, bulk = 0, prv = 1;
	logic [15:0] cmp = 16'h0009, tw = 16'h0000, rxb;
	logic [7:0] reply = 8'h00, cap;
	logic [3:0] nb = 4'h8, cnt, xcnt = 4'h0;
	logic trdy, rval, tbe, tse, rbf, tirq, rirq, sco, scoe, sout, pclk, sin;
	wire logic sclk = scoe ? sco : pclk;
	int bad_count = 0, comparisons = 0, cyc = 0, fcyc = 0, txs = 0;
	always #12.5 clk = ~clk;
	vss_serial vss_serial_inst (.i_sys_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_clock_source_sel(csel),
		.i_bit_order_sel(ord), .i_tx_irq_source_sel(isrc), .i_tx_enable_flag(ten),
		.i_rx_enable_flag(ren), .i_tx_polarity_inv(tinv), .i_rx_polarity_inv(rinv),
		.i_chan0_compare(cmp), .i_tx_buffer_valid(tval), .o_tx_buffer_ready(trdy), .i_tx_buffer(tw),
		.o_rx_buffer_valid(rval), .i_rx_buffer_read(rrd), .o_rx_buffer(rxb), .o_tx_buffer_empty(tbe),
		.o_tx_shift_empty(tse), .o_rx_buffer_full(rbf), .o_tx_irq_request(tirq),
		.o_rx_irq_request(rirq), .i_serial_clock_pin(sclk), .i_serial_in_pin(sin),
		.o_serial_clock_pin(sco), .o_serial_clock_oe(scoe), .o_serial_out_pin(sout));
	vss_peer vss_peer_inst (.i_sys_clk(clk), .i_clr(clr), .i_ext(csel), .i_msb(ord), .i_nbits(nb),
		.i_reply(reply), .i_sclk(sclk), .i_sout(sout), .o_sclk(pclk), .o_sin(sin), .o_cap(cap),
		.o_cnt(cnt));
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : results
	// ****
	// result watcher
	// ****
	always @(posedge clk) begin
		cyc <= cyc + 1;
		rrd <= 1'b0;
		prv <= sco;
		if (cyc == 60000) begin
			bad_count++;
			results();
		end
		if (scoe === 1'b1 && !rst && prv && !sco) fcyc <= cyc;
		if (scoe === 1'b1 && !rst && !prv && sco) `CHK("low time", int'(cmp) + 2, cyc - fcyc)
		if (tirq === 1'b1) begin
			txs <= txs + 1;
			if (!bulk) `CHK("tx irq bits", xcnt, cnt)
		end
		if (rirq === 1'b1) begin
			`CHK("rx irq due", 1'b1, notes.size() != 0)
			if (notes.size() != 0) begin
				nt = notes.pop_front();
				`CHK("rx word", nt.rx, rxb & nt.rm)
				`CHK("peer capture", nt.cap, cap & nt.cm)
				`CHK("rx full", 1'b1, rbf)
				rrd <= !noread;
			end
		end
	end
	// ****
	// stimulus
	// ****
	task automatic send(input logic [2:0] len, input logic ext, input logic hold, input logic rxon,
		input logic [1:0] ovr);
		logic [7:0] d, r, e, m, rr;
		logic [15:0] x, xm;
		logic o, s, ti, ri;
		int n, k, t0;
		n = (len == 3'h0) ? 8 : int'(len);
		d = 8'($urandom);
		r = 8'($urandom);
		{o, s, ti, ri} = 4'($urandom);
		e = 8'h00;
		for (k = 0; k < n; k++) e[k] = d[n - 1 - k];
		e = o ? d : e;
		m = 8'((1 << n) - 1);
		rr = r ^ {8{ri}};
		x = {8'h00, o ? 8'(rr >> (8 - n)) : (rr & m)};
		xm = 16'h80ff;
		if (ovr == 2'h2) {x, xm} = {16'h8000, 16'h8000};
		if (rxon) notes.push_back('{(e ^ {8{ti}}) & m, m, x, xm});
		@(posedge clk);
		{ord, isrc, tinv, rinv, csel, ren, ten, noread} <= {o, s, ti, ri, ext, rxon, !hold, ovr == 2'h1};
		cmp <= 16'(9 + $urandom % 4);
		{reply, nb, xcnt} <= {r, 4'(n), s ? 4'(n) : 4'h0};
		tw <= {5'h00, len, d};
		tval <= 1'b1;
		t0 = txs;
		@(posedge clk);
		while (trdy !== 1'b1) @(posedge clk);
		tval <= 1'b0;
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		if (hold) begin
			repeat (40) @(posedge clk);
			`CHK("held shifter", 1'b1, tse)
			`CHK("held buffer", 1'b0, tbe)
			`CHK("held irq", t0, txs)
			ten <= 1'b1;
		end
		k = 0;
		while ((txs == t0 || tse !== 1'b1) && k < 3000) begin
			@(posedge clk);
			k++;
		end
		repeat (8) @(posedge clk);
		`CHK("pending", 0, notes.size())
		$display("test len %0d ext %0d done", n, ext);
	endtask : send
	task automatic fill();
		int k, t0;
		@(posedge clk);
		{ten, ren, bulk, csel, tval} <= 5'b00101;
		tw <= 16'h0155;
		t0 = txs;
		k = 0;
		repeat (40) begin
			@(posedge clk);
			k += int'(trdy === 1'b1);
		end
		`CHK("words taken", 16, k)
		{ten, tval} <= 2'b10;
		k = 0;
		while ((txs - t0 < 16 || tse !== 1'b1) && k < 5000) begin
			@(posedge clk);
			k++;
		end
		`CHK("chars sent", 16, txs - t0)
		`CHK("drained", 1'b1, tbe)
		$display("test fill done");
	endtask : fill
	initial begin
		void'($urandom(32'h66fc75d6));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		`CHK("reset", 8'b11000110, {tbe, tse, rbf, tirq, rirq, sout, sco, scoe})
		for (int i = 0; i < 16; i++) send(3'(i), i[3], i == 3, i != 5, 2'h0);
		send(3'h0, 1'b0, 1'b0, 1'b1, 2'h1);
		send(3'h0, 1'b0, 1'b0, 1'b1, 2'h2);
		fill();
		results();
	end
endmodule : vss_serial_tb
`default_nettype wire
